//--- dac_serial_write_port_defines.vh
// constants for the dac serial write port
`ifndef DAC_SERIAL_WRITE_PORT_DEFINES_VH
`define DAC_SERIAL_WRITE_PORT_DEFINES_VH
`define WORD_BITS       8
`define BIT_COUNT_W     4
`define WORD_RESET      8'h00
`define BIT_COUNT_FULL  4'h8
`define BIT_COUNT_ZERO  4'h0
`define STATE_IDLE      2'h0
`define STATE_SHIFT     2'h1
`define STATE_FULL      2'h2
`endif

//--- dac_serial_write_port.v
// serial write port of an 8-bit current-output dac, sampled on the system clock
`timescale 1ns/100ps
`default_nettype none
`include "dac_serial_write_port_defines.vh"

module dac_serial_write_port
#(
  parameter WORD_W = `WORD_BITS
)
(
  input  wire              clk,
  input  wire              resetn,
  input  wire              shift_clock,
  input  wire              serial_data_in,
  input  wire              frame_select_n,
  input  wire              output_load_strobe_n,
  output reg  [WORD_W-1:0] dac_word,
  output reg               dac_update,
  output reg               buffers_on,
  output reg               word_ready
);

  // two-flop synchronisers; first stage read only by the second
  reg [1:0] sclk_sync_reg;
  reg [1:0] serial_data_in_sync_reg;
  reg [1:0] fsel_sync_reg;
  reg [1:0] load_sync_reg;
  reg       sclk_prev_reg;
  reg       fsel_prev_reg;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_sync_reg <= 2'h0;
      serial_data_in_sync_reg <= 2'h0;
      fsel_sync_reg <= 2'h3;
      load_sync_reg <= 2'h3;
      sclk_prev_reg <= 1'b0;
      fsel_prev_reg <= 1'b1;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[0], shift_clock};
      serial_data_in_sync_reg <= {serial_data_in_sync_reg[0], serial_data_in};
      fsel_sync_reg <= {fsel_sync_reg[0], frame_select_n};
      load_sync_reg <= {load_sync_reg[0], output_load_strobe_n};
      sclk_prev_reg <= sclk_sync_reg[1];
      fsel_prev_reg <= fsel_sync_reg[1];
    end
  end

  // edge detection shared by frame select and shift clock
  function edge_fall;
    input prev;
    input now;
    begin
      edge_fall = prev & ~now;
    end
  endfunction

  function edge_rise;
    input prev;
    input now;
    begin
      edge_rise = ~prev & now;
    end
  endfunction

  wire fsel_fall = edge_fall(fsel_prev_reg, fsel_sync_reg[1]);
  wire fsel_rise = edge_rise(fsel_prev_reg, fsel_sync_reg[1]);
  wire sclk_fall = edge_fall(sclk_prev_reg, sclk_sync_reg[1]);
  wire load_low  = ~load_sync_reg[1];

  reg [1:0]              state_reg;
  reg [1:0]              state_next;
  reg [`BIT_COUNT_W-1:0] count_reg;
  reg [`BIT_COUNT_W-1:0] count_next;
  reg [WORD_W-1:0]       shift_reg;
  reg [WORD_W-1:0]       shift_next;
  reg [WORD_W-1:0]       dac_next;
  reg                    update_next;
  reg                    buffers_next;
  reg                    ready_next;

  always @*
  begin
    state_next   = state_reg;
    count_next   = count_reg;
    shift_next   = shift_reg;
    dac_next     = dac_word;
    update_next  = 1'b0;
    buffers_next = buffers_on;
    ready_next   = word_ready;
    case (state_reg)
      `STATE_IDLE:
      begin
        if (fsel_fall)
        begin
          state_next   = `STATE_SHIFT;
          count_next   = `BIT_COUNT_ZERO;
          buffers_next = 1'b1;
          ready_next   = 1'b0;
        end
      end
      `STATE_SHIFT:
      begin
        if (fsel_rise)
        begin
          state_next   = `STATE_IDLE;
          buffers_next = 1'b0;
          if (count_reg == `BIT_COUNT_FULL)
          begin
            ready_next = 1'b1;
            if (load_low)
            begin
              dac_next    = shift_reg;
              update_next = 1'b1;
              ready_next  = 1'b0;
            end
          end
        end
        else if (sclk_fall && !fsel_sync_reg[1] && count_reg != `BIT_COUNT_FULL)
        begin
          shift_next = {shift_reg[WORD_W-2:0], serial_data_in_sync_reg[1]};
          count_next = count_reg + 4'h1;
        end
      end
      default:
      begin
        state_next = `STATE_IDLE;
      end
    endcase
    if (state_reg == `STATE_IDLE && word_ready && load_low && !fsel_fall)
    begin
      dac_next    = shift_reg;
      update_next = 1'b1;
      ready_next  = 1'b0;
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg  <= `STATE_IDLE;
      count_reg  <= `BIT_COUNT_ZERO;
      shift_reg  <= `WORD_RESET;
      dac_word   <= `WORD_RESET;
      dac_update <= 1'b0;
      buffers_on <= 1'b0;
      word_ready <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      count_reg  <= count_next;
      shift_reg  <= shift_next;
      dac_word   <= dac_next;
      dac_update <= update_next;
      buffers_on <= buffers_next;
      word_ready <= ready_next;
    end
  end

endmodule
`default_nettype wire

//--- dac_port_sva.sv
// assertions on the dac serial write port
`timescale 1ns/100ps
`default_nettype none
module dac_port_sva(input wire logic clk,resetn,shift_clock,serial_data_in,frame_select_n,output_load_strobe_n,
  input wire logic [7:0] dac_word,input wire logic dac_update,buffers_on,word_ready);
  default clocking @(posedge clk);endclocking
  default disable iff(!resetn);
  property p_pls;dac_update|=>!dac_update;endproperty
  a_pls:assert property(p_pls)else $error("long");
  property p_hld;!dac_update|->$stable(dac_word);endproperty
  a_hld:assert property(p_hld)else $error("moved");
  property p_cls;dac_update|->!buffers_on;endproperty
  a_cls:assert property(p_cls)else $error("in frame");
  property p_rdy;word_ready|->!buffers_on;endproperty
  a_rdy:assert property(p_rdy)else $error("ready");
  property p_on;!frame_select_n[*8]|->buffers_on;endproperty
  a_on:assert property(p_on)else $error("off");
  property p_off;frame_select_n[*8]|->!buffers_on;endproperty
  a_off:assert property(p_off)else $error("on");
  property p_no;output_load_strobe_n[*8]|->!dac_update;endproperty
  a_no:assert property(p_no)else $error("stray");
  property p_ld;word_ready&&!output_load_strobe_n|->##[1:6]dac_update;endproperty
  a_ld:assert property(p_ld)else $error("no load");
endmodule
bind dac_serial_write_port dac_port_sva u_chk(.*);
`default_nettype wire

//--- host_model.sv
// host serial port model
`timescale 1ns/100ps
`default_nettype none
module host_model(output logic shift_clock,serial_data_in,frame_select_n);
  initial {shift_clock,serial_data_in,frame_select_n}=3'h5;
  task send(logic [7:0] w,int n);
    frame_select_n=0;
    for(int i=7;i>7-n;i--)begin serial_data_in=w[i];#62.5 shift_clock=0;#62.5 shift_clock=1;end
    #100 frame_select_n=1;
    serial_data_in=~serial_data_in;
    repeat(n<8?4:0)begin #62.5 shift_clock=~shift_clock;serial_data_in=~serial_data_in;end
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
// testbench for the dac serial write port
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk=0,resetn=0,output_load_strobe_n=1;
  logic [7:0] w,e=8'h00;
  wire shift_clock,serial_data_in,frame_select_n,dac_update,buffers_on,word_ready;
  wire [7:0] dac_word;
  int miscompares=0,n_checks=0,n;
  dac_serial_write_port dut(.*);
  host_model host(.*);
  function logic [7:0] want(logic [7:0] v,int b);return b==8?v:e;endfunction
  task check(logic [7:0] g,x);
    n_checks++;
    if(g!==x)begin miscompares++;$display("CHECK FAILED %0t %h %h",$time,g,x);end
  endtask
  task summarize;
    $display("checks %0d errors %0d",n_checks,miscompares);
    if(miscompares==0&&n_checks>0)$display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial forever #4 clk=~clk;
  initial begin #100000 miscompares++;summarize;end
  initial begin
    void'($urandom(6));
    #33 resetn=1;
    for(int i=0;i<10;i++)begin
      w=i==0?8'h80:i==1?8'h01:8'($urandom);
      n=i==3?5:8;
      @(posedge clk)#1 output_load_strobe_n=i==1||i>1&&$urandom%2;
      host.send(w,n);
      #100 check({7'h0,word_ready},{7'h0,output_load_strobe_n&&n==8});
      @(posedge clk)#1 output_load_strobe_n=0;
      #100 e=want(w,n);
      check(dac_word,e);
    end
    summarize;
  end
endmodule
`default_nettype wire
